// *** tcc_regs.svh ***
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH
// Byte offsets of the register words
`define TCC_OFS_CMPA_LO  12'h000
`define TCC_OFS_CMPA_HI  12'h004
`define TCC_OFS_CMPB_LO  12'h008
`define TCC_OFS_CMPB_HI  12'h00c
`define TCC_OFS_CMPC_LO  12'h010
`define TCC_OFS_CMPC_HI  12'h014
`define TCC_OFS_CAP_LO   12'h018
`define TCC_OFS_CAP_HI   12'h01c
`define TCC_OFS_IRQ_EN   12'h020
`define TCC_OFS_FLAGS    12'h024
`define TCC_OFS_CLEAR    12'h028
`define TCC_OFS_CTRL     12'h02c
// Event bit positions, shared by flags, enables, clears and acks
`define TCC_BIT_WRAP     0
`define TCC_BIT_MATCH_A  1
`define TCC_BIT_MATCH_B  2
`define TCC_BIT_MATCH_C  3
`define TCC_BIT_CAPTURE  5
`define TCC_EVENT_MASK   8'h2f
// Control word fields
`define TCC_CTRL_MODE_LSB   0
`define TCC_CTRL_RISE_BIT   4
`define TCC_CTRL_ACOMP_BIT  5
`define TCC_CTRL_FORCE_LSB  6
`define TCC_CTRL_RD_MASK    8'h3f
// Reset values
`define TCC_RST_CMP      16'h0000
`define TCC_RST_CAP      16'h0000
`define TCC_RST_BYTE     8'h00
`define TCC_RST_CTRL     6'h00
`endif

// *** tcc_pkg.sv ***
package tcc_pkg;
   // Counter core state seen by the compare and capture logic
   typedef struct packed {
      logic [15:0] count_value;
      logic        count_tick;
      logic        count_wrap;
      logic        count_at_top;
   } tcc_core_t;

   typedef logic [7:0]  tcc_byte_t;
   typedef logic [15:0] tcc_word_t;
   typedef logic [3:0]  tcc_mode_t;
endpackage : tcc_pkg

// *** tcc_timer16.sv ***
// How it works
// R1: Three 16-bit compare values, compared continuously.
// R2: Compare writes pass through shared high-byte latch.
// R3: Capture event copies counter into capture value.
// R4: Capture low read loads high byte latch.
// R5: Capture value can serve as counter TOP.
// R6: Enable bits 5,3,2,1,0 gate with global enable.
// R7: Flags at bits 5,3,2,1,0; others zero.
// R8: Capture flag on event, or at TOP in capture-as-TOP modes.
// R9: Match flag one timer tick after equality.
// R10: Force strobe never sets a match flag.
// R11: Wrap flag follows core's mode-aware wrap event.
// R12: Executed interrupt vector clears its flag.
// R13: Writing one clears a flag, zero keeps.
// R14: High byte first, low byte commits both.
// R15: Reserved flag and enable bits read zero.
//
// The APB slave port and the register offsets were left to the implementer.
`include "tcc_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module tcc_timer16
   import tcc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire tcc_core_t   core,
   input  wire logic        capture_input_pin,
   input  wire logic        acomp_out,
   input  wire logic        global_irq_en,
   input  wire logic [7:0]  vector_ack,
   output var  logic [15:0] top_value,
   output var  logic        top_from_capture,
   output var  logic [2:0]  waveform_output_pin,
   output var  logic [7:0]  irq_req,
   output var  logic        irq
);

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic mode_capture_top(input tcc_mode_t m);
      case (m)
         4'h8, 4'ha, 4'hc, 4'he: mode_capture_top = 1'b1;
         default:                mode_capture_top = 1'b0;
      endcase
   endfunction : mode_capture_top

   function automatic logic mode_non_pwm(input tcc_mode_t m);
      case (m)
         4'h0, 4'h4, 4'hc: mode_non_pwm = 1'b1;
         default:          mode_non_pwm = 1'b0;
      endcase
   endfunction : mode_non_pwm

   function automatic logic match_on_tick(input tcc_core_t c, input tcc_word_t cmp);
      match_on_tick = c.count_tick && (c.count_value == cmp);
   endfunction : match_on_tick

   function automatic logic edge_seen(input logic lvl, input logic lvl_prev, input logic rise);
      edge_seen = rise ? (lvl & ~lvl_prev) : (~lvl & lvl_prev);
   endfunction : edge_seen

   function automatic tcc_word_t commit_word(input tcc_byte_t hi, input logic [31:0] d);
      commit_word = {hi, d[7:0]};
   endfunction : commit_word

   // ==========================================================
   // State
   // ==========================================================
   tcc_word_t   cmp_a_reg;
   tcc_word_t   cmp_b_reg;
   tcc_word_t   cmp_c_reg;
   tcc_word_t   cap_reg;
   tcc_byte_t   temp_reg;
   tcc_byte_t   irq_en_reg;
   tcc_byte_t   flags_reg;
   logic [5:0]  ctrl_reg;
   logic        src_prev_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;
   logic [15:0] top_value_reg;
   logic        top_cap_reg;
   logic [2:0]  wave_reg;
   tcc_byte_t   irq_req_reg;
   logic        irq_reg;

   // ==========================================================
   // Bus decode
   // ==========================================================
   // Action happens at the end of the first access cycle; pready
   // follows one cycle later so read data and side effects agree.
   wire logic acc      = psel & penable & ~pready_reg;
   wire logic wr       = acc & pwrite;
   wire logic rd       = acc & ~pwrite;
   wire logic hit_al   = paddr == `TCC_OFS_CMPA_LO;
   wire logic hit_ah   = paddr == `TCC_OFS_CMPA_HI;
   wire logic hit_bl   = paddr == `TCC_OFS_CMPB_LO;
   wire logic hit_bh   = paddr == `TCC_OFS_CMPB_HI;
   wire logic hit_cl   = paddr == `TCC_OFS_CMPC_LO;
   wire logic hit_ch   = paddr == `TCC_OFS_CMPC_HI;
   wire logic hit_pl   = paddr == `TCC_OFS_CAP_LO;
   wire logic hit_ph   = paddr == `TCC_OFS_CAP_HI;
   wire logic hit_en   = paddr == `TCC_OFS_IRQ_EN;
   wire logic hit_fl   = paddr == `TCC_OFS_FLAGS;
   wire logic hit_clr  = paddr == `TCC_OFS_CLEAR;
   wire logic hit_ctl  = paddr == `TCC_OFS_CTRL;
   wire logic mapped   = hit_al | hit_ah | hit_bl | hit_bh | hit_cl | hit_ch
                        | hit_pl | hit_ph | hit_en | hit_fl | hit_clr | hit_ctl;
   wire logic wr_hi    = wr & (hit_ah | hit_bh | hit_ch | hit_ph);

   // ==========================================================
   // Control fields
   // ==========================================================
   wire tcc_mode_t mode     = ctrl_reg[`TCC_CTRL_MODE_LSB +: 4];
   wire logic      cap_top  = mode_capture_top(mode);
   wire logic [2:0] force_s = (wr & hit_ctl & mode_non_pwm(mode)) ?
                              pwdata[`TCC_CTRL_FORCE_LSB +: 3] : 3'h0;

   // ==========================================================
   // Compare and capture events
   // ==========================================================
   // Equality seen on a timer tick sets the flag at the edge that
   // ends that tick, i.e. one timer clock after equality began.
   wire logic [2:0] match_set = {                               // R9
      match_on_tick(core, cmp_c_reg),                           // R1
      match_on_tick(core, cmp_b_reg),
      match_on_tick(core, cmp_a_reg)};
   wire logic cap_src  = ctrl_reg[`TCC_CTRL_ACOMP_BIT] ? acomp_out
                                                       : capture_input_pin; // R3
   wire logic cap_edge = edge_seen(cap_src, src_prev_reg, ctrl_reg[`TCC_CTRL_RISE_BIT]);
   // In capture-as-TOP modes the pin is disconnected
   wire logic capture  = cap_edge & ~cap_top;                  // R3
   wire logic cap_flag = cap_top ? core.count_at_top : capture; // R8

   wire tcc_byte_t ev_set;
   assign ev_set[`TCC_BIT_WRAP]    = core.count_wrap;          // R11
   assign ev_set[`TCC_BIT_MATCH_A] = match_set[0];             // R10
   assign ev_set[`TCC_BIT_MATCH_B] = match_set[1];
   assign ev_set[`TCC_BIT_MATCH_C] = match_set[2];
   assign ev_set[4]                = 1'b0;
   assign ev_set[`TCC_BIT_CAPTURE] = cap_flag;
   assign ev_set[7:6]              = 2'h0;

   wire tcc_byte_t sw_clr = (wr & (hit_fl | hit_clr)) ? pwdata[7:0] : 8'h00; // R13
   wire tcc_byte_t ev_clr = sw_clr | vector_ack;               // R12
   // Set beats clear so a coincident event is not lost
   wire tcc_byte_t flags_next = ((flags_reg & ~ev_clr) | ev_set)
                                & `TCC_EVENT_MASK;             // R7
   wire tcc_byte_t req_next   = flags_next & irq_en_reg
                                & {8{global_irq_en}};          // R6

   // ==========================================================
   // Read mux
   // ==========================================================
   wire tcc_byte_t rd_byte =
        hit_al ? cmp_a_reg[7:0] : hit_ah ? cmp_a_reg[15:8] :
        hit_bl ? cmp_b_reg[7:0] : hit_bh ? cmp_b_reg[15:8] :
        hit_cl ? cmp_c_reg[7:0] : hit_ch ? cmp_c_reg[15:8] :
        hit_pl ? cap_reg[7:0]   : hit_ph ? temp_reg        :  // R4
        hit_en ? irq_en_reg     : hit_fl ? flags_reg       :  // R15
        hit_ctl ? (tcc_byte_t'(ctrl_reg) & `TCC_CTRL_RD_MASK) : 8'h00;

   // ==========================================================
   // Bus slave registers
   // ==========================================================
   // Answer one cycle after the access is taken, then drop again
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= acc;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_reg <= 1'b0;
      end else begin
         pslverr_reg <= acc & ~mapped;
      end
   end

   // Zero outside read answers keeps stale data off the bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else begin
         prdata_reg <= rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // ==========================================================
   // Shared high-byte latch
   // ==========================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         temp_reg <= `TCC_RST_BYTE;
      end else if (wr_hi) begin
         temp_reg <= pwdata[7:0];                              // R14
      end else if (rd & hit_pl) begin
         temp_reg <= cap_reg[15:8];                            // R4
      end
   end

   // ==========================================================
   // Compare values, committed whole by the low-byte write
   // ==========================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_a_reg <= `TCC_RST_CMP;
      end else if (wr & hit_al) begin
         cmp_a_reg <= commit_word(temp_reg, pwdata);             // R2
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_b_reg <= `TCC_RST_CMP;
      end else if (wr & hit_bl) begin
         cmp_b_reg <= commit_word(temp_reg, pwdata);             // R2
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_c_reg <= `TCC_RST_CMP;
      end else if (wr & hit_cl) begin
         cmp_c_reg <= commit_word(temp_reg, pwdata);             // R14
      end
   end

   // ==========================================================
   // Capture value
   // ==========================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_prev_reg <= 1'b0;
      end else begin
         src_prev_reg <= cap_src;
      end
   end

   // Software may write it as TOP; a hardware capture wins a tie
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_reg <= `TCC_RST_CAP;
      end else if (capture) begin
         cap_reg <= core.count_value;                            // R3
      end else if (wr & hit_pl) begin
         cap_reg <= commit_word(temp_reg, pwdata);               // R5
      end
   end

   // ==========================================================
   // Control, enables, flags
   // ==========================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `TCC_RST_CTRL;
      end else if (wr & hit_ctl) begin
         ctrl_reg <= pwdata[5:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_reg <= `TCC_RST_BYTE;
      end else if (wr & hit_en) begin
         irq_en_reg <= pwdata[7:0] & `TCC_EVENT_MASK;            // R15
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_reg <= `TCC_RST_BYTE;
      end else begin
         flags_reg <= flags_next;                                // R13
      end
   end

   // ==========================================================
   // Outputs toward core, pins and interrupt controller
   // ==========================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         top_value_reg <= `TCC_RST_CMP;
      end else begin
         top_value_reg <= cap_top ? cap_reg : cmp_a_reg;         // R5
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         top_cap_reg <= 1'b0;
      end else begin
         top_cap_reg <= cap_top;
      end
   end

   // Pins toggle on real or forced match; only the real one flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wave_reg <= 3'h0;
      end else begin
         wave_reg <= wave_reg ^ (match_set | force_s);           // R10
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_req_reg <= 8'h00;
      end else begin
         irq_req_reg <= req_next;                                // R6
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |req_next;                                   // R6
      end
   end

   assign prdata              = prdata_reg;
   assign pready              = pready_reg;
   assign pslverr             = pslverr_reg;
   assign top_value           = top_value_reg;
   assign top_from_capture    = top_cap_reg;
   assign waveform_output_pin = wave_reg;
   assign irq_req             = irq_req_reg;
   assign irq                 = irq_reg;

endmodule : tcc_timer16

`default_nettype wire

// *** tcc_core_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========
// Counter core stand-in, one tick per cycle while run is high
module tcc_core_model
   import tcc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        run,
   input  wire logic        load,
   input  wire logic [15:0] load_val,
   output var  tcc_core_t   core
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core <= '0;
      end else begin
         core.count_tick   <= run;
         core.count_wrap   <= core.count_tick && core.count_value == 16'hffff;
         core.count_at_top <= core.count_tick && core.count_value == 16'hffff;
         core.count_value  <= load ? load_val : core.count_value + 16'(core.count_tick);
      end
   end
endmodule : tcc_core_model
`default_nettype wire

// *** tcc_timer16_props.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========
// Port-level checks
module tcc_timer16_props (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        global_irq_en,
   input wire logic [7:0]  irq_req,
   input wire logic        irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_after: assert property (psel && penable && !pready |=> pready)
      else $error("access phase not answered next cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside an access phase");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside an answer");
   a_rdata_byte: assert property (prdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_req_reserved: assert property (irq_req[7:6] == 2'b00 && !irq_req[4])
      else $error("request on a reserved bit");
   a_global_gate: assert property (!global_irq_en |=> irq_req == 8'h00)
      else $error("request while globally disabled");
   a_irq_any: assert property (irq == (|irq_req))
      else $error("irq differs from OR of requests");
endmodule : tcc_timer16_props
bind tcc_timer16 tcc_timer16_props i_props (.pclk, .presetn, .psel, .penable, .prdata,
   .pready, .pslverr, .global_irq_en, .irq_req, .irq);
`default_nettype wire

// *** tcc_timer16_bench.sv ***
`include "tcc_regs.svh"
`timescale 1ns/10ps
`default_nettype none
// ==========
// Bench top
module tcc_timer16_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic        cap_pin, acomp, gie, run, load, top_cap, last_err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat, v;
   logic [15:0] load_val, top_value, x;
   logic [7:0]  ack, irq_req;
   logic [2:0]  wave;
   tcc_pkg::tcc_core_t core;
   int          bad_count = 0, n_checks = 0, cyc = 0, i, seed;

   always #25 pclk = ~pclk;

   tcc_core_model i_core (.pclk, .presetn, .run, .load, .load_val, .core);
   tcc_timer16 i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .core, .capture_input_pin(cap_pin), .acomp_out(acomp),
      .global_irq_en(gie), .vector_ack(ack), .top_value, .top_from_capture(top_cap),
      .waveform_output_pin(wave), .irq_req, .irq);

   // ==========
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [31:0] exp_req(input logic [7:0] f, input logic [7:0] en,
                                           input logic g);
      return 32'(f & en & {8{g}} & `TCC_EVENT_MASK);
   endfunction : exp_req

   // Idle cycle first, so no signal is assigned twice in one step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat     = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat, {24'h0, e});
   endtask : rd

   task automatic spin(input logic [15:0] s);
      load_val <= s;
      load     <= 1'b1;
      @(posedge pclk);
      load     <= 1'b0;
      run      <= 1'b1;
      repeat (12) @(posedge pclk);
      run      <= 1'b0;
   endtask : spin

   // Counter stopped, so the captured value is known
   task automatic cap(input logic [15:0] c, input logic use_acomp);
      load_val <= c;
      load     <= 1'b1;
      @(posedge pclk);
      load     <= 1'b0;
      {acomp, cap_pin} <= use_acomp ? 2'b10 : 2'b01;
      @(posedge pclk);
      {acomp, cap_pin} <= 2'b00;
      repeat (2) @(posedge pclk);
   endtask : cap

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 4000) begin
         bad_count++;
         $display("ERROR %0t got %h exp %h", $time, cyc, 0);
         test_done();
      end
   end

   // ==========
   // Sequence
   initial begin
      seed = 32'h682ba459;
      pclk = 1'b0;
      presetn <= 1'b0;
      {psel, penable, pwrite, cap_pin, acomp, gie, run, load} <= 8'h00;
      {paddr, pwdata, load_val, ack} <= '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(`TCC_OFS_FLAGS, 8'h00);
      rd(`TCC_OFS_IRQ_EN, 8'h00);
      rd(`TCC_OFS_CAP_HI, 8'h00);
      rd(12'hff0, 8'h00);
      chk(32'(last_err), 32'h1);
      $display("test reset done");
      for (i = 0; i < 3; i++) begin
         v = $random(seed);
         v[15:14] = 2'b01;
         x = top_value;
         apb(1'b1, 12'(8 * i + 4), v >> 8);
         if (i == 0) chk(32'(top_value), 32'(x));
         apb(1'b1, 12'(8 * i), v);
         @(posedge pclk);
         if (i == 0) chk(32'(top_value), 32'(v[15:0]));
         rd(12'(8 * i), v[7:0]);
         rd(12'(8 * i + 4), v[15:8]);
      end
      $display("test compare done");
      apb(1'b1, `TCC_OFS_IRQ_EN, 32'hff);
      rd(`TCC_OFS_IRQ_EN, 8'h2f);
      apb(1'b1, `TCC_OFS_CMPA_HI, 32'h01);
      apb(1'b1, `TCC_OFS_CMPA_LO, 32'h05);
      gie <= 1'b1;
      spin(16'h0100);
      rd(`TCC_OFS_FLAGS, 8'h02);
      chk(32'(irq_req), exp_req(8'h02, 8'hff, 1'b1));
      gie <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h0);
      gie <= 1'b1;
      apb(1'b1, `TCC_OFS_FLAGS, 32'hfd);
      rd(`TCC_OFS_FLAGS, 8'h02);
      chk(32'(irq), 32'h1);
      ack <= 8'h02;
      @(posedge pclk);
      ack <= 8'h00;
      rd(`TCC_OFS_FLAGS, 8'h00);
      $display("test match done");
      v = $random(seed);
      cap(v[15:0], 1'b0);
      rd(`TCC_OFS_CAP_LO, v[7:0]);
      apb(1'b1, `TCC_OFS_CTRL, 32'h30);
      cap(v[31:16], 1'b1);
      rd(`TCC_OFS_CAP_HI, v[15:8]);
      rd(`TCC_OFS_CAP_LO, v[23:16]);
      rd(`TCC_OFS_CAP_HI, v[31:24]);
      rd(`TCC_OFS_FLAGS, 8'h20);
      apb(1'b1, `TCC_OFS_FLAGS, 32'h20);
      rd(`TCC_OFS_FLAGS, 8'h00);
      $display("test capture done");
      x = 16'(wave);
      apb(1'b1, `TCC_OFS_CTRL, 32'h40);
      chk(32'(wave), 32'(x[2:0] ^ 3'b001));
      rd(`TCC_OFS_FLAGS, 8'h00);
      spin(16'hfffc);
      rd(`TCC_OFS_FLAGS, 8'h01);
      apb(1'b1, `TCC_OFS_CLEAR, 32'h01);
      rd(`TCC_OFS_FLAGS, 8'h00);
      rd(`TCC_OFS_CLEAR, 8'h00);
      $display("test force and wrap done");
      apb(1'b1, `TCC_OFS_CTRL, 32'h0c);
      @(posedge pclk);
      chk(32'(top_cap), 32'h1);
      chk(32'(top_value), 32'(v[31:16]));
      spin(16'hfffc);
      rd(`TCC_OFS_FLAGS, 8'h21);
      $display("test capture top done");
      test_done();
   end
endmodule : tcc_timer16_bench
`default_nettype wire
